// ---- rtl/jtap_tap.v ----
// Test access port controller sampled by the system clock.
`timescale 1ns/1ps
`default_nettype none
`include "jtap_consts.vh"
module jtap_tap #(
  parameter IDCODE = `JTAP_IDCODE  // Arbitrary identity value.
) (
  // System clock and reset
  input  wire        sys_clk,
  input  wire        reset_n,
  // Test port pins
  input  wire        tck,
  input  wire        tms,
  input  wire        tdi,
  input  wire        trst_n,
  output wire        tdo_o,
  output wire        tdo_oe,
  // Controller status
  output wire [3:0]  tap_state,
  output wire [3:0]  tap_ir
);
  wire       tck_s;
  wire       tms_s;
  wire       tdi_s;
  wire       trst_s_n;
  reg        tck_q;
  reg  [3:0] state_q;
  reg  [3:0] state_d;
  reg  [3:0] ir_shift_q;
  reg  [3:0] ir_q;
  reg [31:0] dr_shift_q;
  reg        tdo_q;
  reg        tdo_oe_q;
  wire       rise;
  wire       fall;
  wire       trst_a_n;

  // Reset levels of the pin stages, bit order trst, tdi, tms, tck.
  localparam [3:0] PIN_RST = 4'b0110;
  wire [3:0] pin_raw;
  wire [3:0] pin_sync;
  genvar     gi;

  // Gather the pins so that one loop builds all synchronisers.
  assign pin_raw = {trst_n, tdi, tms, tck};

  // Every pin passes two flip-flops; only trst_n is also read directly, by the asynchronous test reset.
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
      jtap_sync #(
        .RST_VAL (PIN_RST[gi])
      ) jtap_sync_inst (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .din     (pin_raw[gi]),
        .dout    (pin_sync[gi])
      );
    end
  endgenerate

  // Split the synchronised pins back into named signals.
  assign tck_s    = pin_sync[0];
  assign tms_s    = pin_sync[1];
  assign tdi_s    = pin_sync[2];
  assign trst_s_n = pin_sync[3];

  // True in the two shift states, where the data output is driven.
  function in_shift;
    input [3:0] st;
    begin
      in_shift = (st == `JTAP_ST_SHIFT_IR) || (st == `JTAP_ST_SHIFT_DR);
    end
  endfunction

  // Test reset acts asynchronously on the controller state.
  assign trst_a_n = reset_n & trst_n;

  // Edge detection of the sampled test clock.
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tck_q <= 1'b0;
    end else begin
      tck_q <= tck_s;
    end
  end
  assign rise = tck_s & ~tck_q;
  assign fall = ~tck_s & tck_q;

  // Next-state table of the standard controller.
  always @* begin
    case (state_q)
      `JTAP_ST_RESET:    state_d = tms_s ? `JTAP_ST_RESET : `JTAP_ST_IDLE;
      `JTAP_ST_IDLE:     state_d = tms_s ? `JTAP_ST_SEL_DR : `JTAP_ST_IDLE;
      `JTAP_ST_SEL_DR:   state_d = tms_s ? `JTAP_ST_SEL_IR : `JTAP_ST_CAP_DR;
      `JTAP_ST_CAP_DR:   state_d = tms_s ? `JTAP_ST_EXIT1_DR
                                         : `JTAP_ST_SHIFT_DR;
      `JTAP_ST_SHIFT_DR: state_d = tms_s ? `JTAP_ST_EXIT1_DR
                                         : `JTAP_ST_SHIFT_DR;
      `JTAP_ST_EXIT1_DR: state_d = tms_s ? `JTAP_ST_UPD_DR
                                         : `JTAP_ST_PAUSE_DR;
      `JTAP_ST_PAUSE_DR: state_d = tms_s ? `JTAP_ST_EXIT2_DR
                                         : `JTAP_ST_PAUSE_DR;
      `JTAP_ST_EXIT2_DR: state_d = tms_s ? `JTAP_ST_UPD_DR
                                         : `JTAP_ST_SHIFT_DR;
      `JTAP_ST_UPD_DR:   state_d = tms_s ? `JTAP_ST_SEL_DR : `JTAP_ST_IDLE;
      `JTAP_ST_SEL_IR:   state_d = tms_s ? `JTAP_ST_RESET : `JTAP_ST_CAP_IR;
      `JTAP_ST_CAP_IR:   state_d = tms_s ? `JTAP_ST_EXIT1_IR
                                         : `JTAP_ST_SHIFT_IR;
      `JTAP_ST_SHIFT_IR: state_d = tms_s ? `JTAP_ST_EXIT1_IR
                                         : `JTAP_ST_SHIFT_IR;
      `JTAP_ST_EXIT1_IR: state_d = tms_s ? `JTAP_ST_UPD_IR
                                         : `JTAP_ST_PAUSE_IR;
      `JTAP_ST_PAUSE_IR: state_d = tms_s ? `JTAP_ST_EXIT2_IR
                                         : `JTAP_ST_PAUSE_IR;
      `JTAP_ST_EXIT2_IR: state_d = tms_s ? `JTAP_ST_UPD_IR
                                         : `JTAP_ST_SHIFT_IR;
      `JTAP_ST_UPD_IR:   state_d = tms_s ? `JTAP_ST_SEL_DR : `JTAP_ST_IDLE;
      default:           state_d = `JTAP_ST_RESET;
    endcase
  end

  // State advances on rising edges; five high mode bits reach reset.
  always @(posedge sys_clk or negedge trst_a_n) begin
    if (!trst_a_n) begin
      state_q <= `JTAP_ST_RESET;
    end else if (!trst_s_n) begin
      state_q <= `JTAP_ST_RESET;
    end else if (rise) begin
      state_q <= state_d;
    end
  end

  // Instruction and data shift paths capture input on rising edges.
  always @(posedge sys_clk or negedge trst_a_n) begin
    if (!trst_a_n) begin
      ir_shift_q <= `JTAP_IR_CAPTURE;
      ir_q       <= `JTAP_IR_RESET;
      dr_shift_q <= 32'h0000_0000;
    end else if (!trst_s_n) begin
      ir_shift_q <= `JTAP_IR_CAPTURE;
      ir_q       <= `JTAP_IR_RESET;
      dr_shift_q <= 32'h0000_0000;
    end else if (rise) begin
      case (state_q)
        `JTAP_ST_RESET: begin
          ir_q <= `JTAP_IR_RESET;
        end
        `JTAP_ST_CAP_IR: begin
          ir_shift_q <= `JTAP_IR_CAPTURE;
        end
        `JTAP_ST_SHIFT_IR: begin
          ir_shift_q <= {tdi_s, ir_shift_q[3:1]};
        end
        `JTAP_ST_UPD_IR: begin
          ir_q <= ir_shift_q;
        end
        `JTAP_ST_CAP_DR: begin
          dr_shift_q <= (ir_q == `JTAP_IR_IDCODE) ? IDCODE : 32'h0000_0000;
        end
        `JTAP_ST_SHIFT_DR: begin
          if (ir_q == `JTAP_IR_IDCODE) begin
            dr_shift_q <= {tdi_s, dr_shift_q[31:1]};
          end else begin
            dr_shift_q <= {31'h0000_0000, tdi_s};
          end
        end
        default: begin
          ir_q <= ir_q;
        end
      endcase
      // Entering test-logic-reset selects the reset instruction at once.
      if (state_d == `JTAP_ST_RESET) begin
        ir_q <= `JTAP_IR_RESET;
      end
    end
  end

  // Data output and its enable change on falling edges.
  always @(posedge sys_clk or negedge trst_a_n) begin
    if (!trst_a_n) begin
      tdo_q    <= 1'b0;
      tdo_oe_q <= 1'b0;
    end else if (!trst_s_n) begin
      tdo_q    <= 1'b0;
      tdo_oe_q <= 1'b0;
    end else if (fall) begin
      tdo_oe_q <= in_shift(state_q);
      tdo_q    <= (state_q == `JTAP_ST_SHIFT_IR) ? ir_shift_q[0]
                                                 : dr_shift_q[0];
    end
  end

  assign tdo_o     = tdo_q;
  assign tdo_oe    = tdo_oe_q;
  assign tap_state = state_q;
  assign tap_ir    = ir_q;
endmodule
`default_nettype wire

// ---- inc/jtap_consts.vh ----
// Constants for the test access port controller.
`ifndef JTAP_CONSTS_VH
`define JTAP_CONSTS_VH
`define JTAP_ST_RESET     4'h0
`define JTAP_ST_IDLE      4'h1
`define JTAP_ST_SEL_DR    4'h2
`define JTAP_ST_CAP_DR    4'h3
`define JTAP_ST_SHIFT_DR  4'h4
`define JTAP_ST_EXIT1_DR  4'h5
`define JTAP_ST_PAUSE_DR  4'h6
`define JTAP_ST_EXIT2_DR  4'h7
`define JTAP_ST_UPD_DR    4'h8
`define JTAP_ST_SEL_IR    4'h9
`define JTAP_ST_CAP_IR    4'ha
`define JTAP_ST_SHIFT_IR  4'hb
`define JTAP_ST_EXIT1_IR  4'hc
`define JTAP_ST_PAUSE_IR  4'hd
`define JTAP_ST_EXIT2_IR  4'he
`define JTAP_ST_UPD_IR    4'hf
`define JTAP_IR_WIDTH     4
`define JTAP_IR_RESET     4'h1
`define JTAP_IR_CAPTURE   4'h1
`define JTAP_IR_BYPASS    4'hf
`define JTAP_IR_IDCODE    4'h1
`define JTAP_IDCODE       32'h0000_0001
`endif

// ---- rtl/jtap_sync.v ----
// Two-stage synchroniser for one pin bit with reset value.
`timescale 1ns/1ps
`default_nettype none
module jtap_sync #(
  parameter RST_VAL = 1'b0
) (
  // Clock and reset
  input  wire sys_clk,
  input  wire reset_n,
  // Data
  input  wire din,
  output wire dout
);
  reg meta_q;
  reg sync_q;

  // The first stage feeds only the second stage.
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

  assign dout = sync_q;
endmodule
`default_nettype wire

// ---- sim/jtap_tap_properties.sv ----
// Pin level checks for the test access port controller.
`timescale 1ns/1ps
`default_nettype none
module jtap_tap_properties (
  // Clock and reset
  input wire logic       sys_clk,
  input wire logic       reset_n,
  // Test port pins
  input wire logic       tck,
  input wire logic       tms,
  input wire logic       tdi,
  input wire logic       trst_n,
  input wire logic       tdo_o,
  input wire logic       tdo_oe,
  // Controller status
  input wire logic [3:0] tap_state,
  input wire logic [3:0] tap_ir
);
  logic [1:0] tk_q;
  logic       tdi_q;
  logic [2:0] hi_q;
  wire        rise = tk_q[0] & ~tk_q[1];
  // Samples the test clock pin and counts rises with mode select high.
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tk_q  <= 2'h0;
      tdi_q <= 1'b0;
      hi_q  <= 3'h0;
    end else begin
      tk_q <= {tk_q[0], tck};
      if (rise) begin
        tdi_q <= tdi;
        hi_q  <= !tms ? 3'h0 : (hi_q == 3'h7 ? hi_q : hi_q + 3'h1);
      end
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  property p_graph;
    trst_n && $past(tap_state) == 4'h4 && tap_state != 4'h4 |-> tap_state == 4'h5;
  endproperty
  a_graph: assert property (p_graph) else $error("bad exit from shift");
  property p_tck_only;
    trst_n && !$stable(tap_state) |-> tck;
  endproperty
  a_tck_only: assert property (p_tck_only) else $error("state moved");
  property p_echo;
    tap_ir == 4'hf && tap_state == 4'h4 && $past(tdo_oe) && !$stable(tdo_o)
      |-> tdo_o == tdi_q;
  endproperty
  a_echo: assert property (p_echo) else $error("bypass echo wrong");
  property p_step;
    tap_state == 4'h0 && rise && !tms && trst_n |-> ##[1:6] tap_state == 4'h1;
  endproperty
  a_step: assert property (p_step) else $error("no step to idle");
  property p_drive;
    $rose(tdo_oe) |-> tap_state == 4'h4 || tap_state == 4'hb;
  endproperty
  a_drive: assert property (p_drive) else $error("driven outside shift");
  property p_fall;
    trst_n && (!$stable(tdo_o) || !$stable(tdo_oe)) |-> !tck;
  endproperty
  a_fall: assert property (p_fall) else $error("output moved, clock high");
  property p_trst;
    !trst_n |-> tap_state == 4'h0 && !tdo_oe;
  endproperty
  a_trst: assert property (p_trst) else $error("test reset ignored");
  property p_five;
    $rose(hi_q == 3'h5) |-> ##[0:8] tap_state == 4'h0;
  endproperty
  a_five: assert property (p_five) else $error("five highs, no reset");
  c_shift: cover property (tdo_oe && tap_state == 4'h4);
  c_five: cover property (hi_q == 3'h5);
  c_trst: cover property (!trst_n && tap_ir == 4'h1);
endmodule
bind jtap_tap jtap_tap_properties jtap_tap_properties_inst (
  .sys_clk(sys_clk), .reset_n(reset_n), .tck(tck), .tms(tms), .tdi(tdi),
  .trst_n(trst_n), .tdo_o(tdo_o), .tdo_oe(tdo_oe), .tap_state(tap_state),
  .tap_ir(tap_ir));
`default_nettype wire

// ---- sim/jtap_probe.sv ----
// Probe model that drives the test port pins with its own clock.
`timescale 1ns/1ps
`default_nettype none
module jtap_probe #(
  parameter realtime HALF = 62.5
) (
  // Pins toward the port
  output logic     tck,
  output logic     tms,
  output logic     tdi,
  output logic     trst_n,
  // Answer from the port
  input wire logic tdo_o,
  input wire logic tdo_oe
);
  // Test reset is held from power up until released.
  initial begin
    tck    = 1'b0;
    tms    = 1'b1;
    tdi    = 1'b1;
    trst_n = 1'b0;
  end
  task set_trst(input logic v);
    trst_n = v;
  endtask
  // Pins change while the clock is low; the clock stands still between calls.
  task cycle(input logic m, input logic d, output logic q, output logic e);
    tms = m;
    tdi = d;
    #HALF tck = 1'b1;
    q = tdo_o;
    e = tdo_oe;
    #HALF tck = 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- sim/jtap_tap_tb_top.sv ----
// Bench that compares the controller with a state model.
`timescale 1ns/1ps
`default_nettype none
module jtap_tap_tb_top;
  localparam logic [63:0] NX0 = 64'h1bdd_bba1_4664_4311;
  localparam logic [63:0] NX1 = 64'h2fef_cc02_8785_5920;
  localparam logic [31:0] IDV = 32'h5a3c_96e1; // Arbitrary identity value.
  logic        sys_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        tck, tms, tdi, trst_n, tdo_o, tdo_oe;
  logic [3:0]  tap_state, tap_ir, s, irs, ir;
  logic [31:0] dr, rnd;
  int          failures = 0;
  int          samples_checked = 0;
  always #2 sys_clk = ~sys_clk;
  jtap_tap #(.IDCODE(IDV)) jtap_tap_inst (.sys_clk(sys_clk),
    .reset_n(reset_n), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n),
    .tdo_o(tdo_o), .tdo_oe(tdo_oe), .tap_state(tap_state), .tap_ir(tap_ir));
  jtap_probe jtap_probe_inst (.tck(tck), .tms(tms), .tdi(tdi),
    .trst_n(trst_n), .tdo_o(tdo_o), .tdo_oe(tdo_oe));
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction
  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One test clock; the model predicts the output and the next state.
  task step(input logic m, input logic d);
    logic q, e;
    jtap_probe_inst.cycle(m, d, q, e);
    if (s == 4'h4 || s == 4'hb) check(q, s == 4'hb ? irs[0] : dr[0]);
    check(e, s == 4'h4 || s == 4'hb);
    if (s == 4'h3) dr = ir == 4'h1 ? IDV : 32'h0;
    if (s == 4'h4) dr = ir == 4'h1 ? {d, dr[31:1]} : {31'h0, d};
    if (s == 4'ha) irs = 4'h1;
    if (s == 4'hb) irs = {d, irs[3:1]};
    if (s == 4'hf) ir = irs;
    s = m ? NX1[s*4 +: 4] : NX0[s*4 +: 4];
    if (s == 4'h0) ir = 4'h1;
    repeat (8) @(posedge sys_clk);
    #1 check(tap_state, s);
  endtask
  // Mode select bits go out first bit first; data in is random or high.
  task run(input logic [31:0] ms, input int n, input logic rd);
    for (int i = 0; i < n; i++) begin
      rnd = xs(rnd);
      step(ms[i], rd ? rnd[0] : 1'b1);
    end
  endtask
  task stop_test;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Identity shift, bypass load and echo, five highs, then test reset.
  initial begin
    s = 4'h0;
    ir = 4'h1;
    irs = 4'h0;
    dr = 32'h0;
    rnd = 32'h2b33;
    repeat (6) @(posedge sys_clk);
    #1 reset_n = 1'b1;
    @(posedge sys_clk);
    #1 check({tdo_oe, tap_state}, 32'h0);
    jtap_probe_inst.set_trst(1'b1);
    repeat (8) @(posedge sys_clk);
    #1 run(32'h2, 4, 1'b0);
    run(32'h8000_0000, 32, 1'b1);
    run(32'h7, 5, 1'b0);
    run(32'h8, 4, 1'b0);
    run(32'h1, 2, 1'b0);
    check(tap_ir, 4'hf);
    run(32'h00f8_0001, 24, 1'b1);
    check(tap_ir, 4'h1);
    run(32'h2, 8, 1'b1);
    jtap_probe_inst.set_trst(1'b0);
    @(posedge sys_clk);
    #1 check({tdo_oe, tap_state}, 32'h0);
    stop_test;
  end
endmodule
`default_nettype wire
